// >>> hw/motion_cmd_pkg.sv
package motion_cmd_pkg;
  // frame and register widths
  localparam int DATA_W = 32;
  localparam int PC_W = 16;
  localparam int IDX_W = 6;
  localparam int PARAM_DEPTH = 64;
  localparam int NUM_BANKS = 4;
  localparam int NUM_SRC = 8;
  localparam int NUM_ERR = 5;

  // device address on the command link, value is arbitrary
  localparam logic [7:0] DEV_ADDR = 8'h01;

  // instruction codes
  localparam logic [7:0] OP_IRQ_ENABLE = 8'd25;
  localparam logic [7:0] OP_IRQ_DISABLE = 8'd26;
  localparam logic [7:0] OP_ACCU_TO_AXIS = 8'd34;
  localparam logic [7:0] OP_ACCU_TO_GLOBAL = 8'd35;
  localparam logic [7:0] OP_CLEAR_ERRORS = 8'd36;
  localparam logic [7:0] OP_VECTOR_DEFINE = 8'd37;
  localparam logic [7:0] OP_IRQ_RETURN = 8'd38;

  // special operands
  localparam logic [7:0] SRC_GLOBAL = 8'd255;
  localparam logic [7:0] CLE_ALL = 8'd0;
  localparam logic [7:0] CLE_LAST = 8'd5;
  localparam logic [7:0] GBANK_0 = 8'd0;
  localparam logic [7:0] GBANK_USER = 8'd2;
  localparam logic [7:0] GBANK_3 = 8'd3;

  // storage bank selectors
  localparam logic [1:0] SEL_AXIS = 2'h0;
  localparam logic [1:0] SEL_G0 = 2'h1;
  localparam logic [1:0] SEL_G2 = 2'h2;
  localparam logic [1:0] SEL_G3 = 2'h3;

  // reply status codes
  localparam logic [7:0] ST_OK = 8'd100;
  localparam logic [7:0] ST_BAD_CSUM = 8'd1;
  localparam logic [7:0] ST_BAD_CMD = 8'd2;
  localparam logic [7:0] ST_BAD_TYPE = 8'd3;
  localparam logic [7:0] ST_BAD_VALUE = 8'd4;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FRAME_HDR = 8'h04;
  localparam logic [7:0] REG_FRAME_VAL = 8'h08;
  localparam logic [7:0] REG_FRAME_CSUM = 8'h0C;
  localparam logic [7:0] REG_ACCU = 8'h10;
  localparam logic [7:0] REG_XREG = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;
  localparam logic [7:0] REG_REPLY = 8'h1C;
  localparam logic [7:0] REG_ERR_FLAGS = 8'h20;
  localparam logic [7:0] REG_IRQ_EN = 8'h24;
  localparam logic [7:0] REG_INT_STAT = 8'h28;
  localparam logic [7:0] REG_INT_MASK = 8'h2C;
  localparam logic [7:0] REG_PSEL = 8'h30;
  localparam logic [7:0] REG_PDATA = 8'h34;
  localparam logic [7:0] REG_CPU_FLAGS = 8'h38;

  // field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_STANDALONE = 1;
  localparam int EN_GLOBAL = 8;
  localparam int INT_DONE = 0;
  localparam int INT_REJECT = 1;
  localparam int INT_ENTRY = 2;
  localparam int INT_W = 3;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// >>> hw/param_if.sv
`timescale 1ns/1ps
// one parameter bank: a write port and an independent read port
interface param_if;
  import motion_cmd_pkg::*;
  logic we;
  logic [IDX_W-1:0] widx;
  logic [DATA_W-1:0] wdata;
  logic [IDX_W-1:0] ridx;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output widx, output wdata, output ridx, input rdata);
  modport store (input we, input widx, input wdata, input ridx, output rdata);
endinterface

// >>> hw/param_store.sv
`timescale 1ns/1ps
module param_store (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  param_if.store port // write and read port
);
  import motion_cmd_pkg::*;

  logic [DATA_W-1:0] mem_q [PARAM_DEPTH];
  logic [DATA_W-1:0] mem_d [PARAM_DEPTH];

  // next contents: one word replaced on a write
  always_comb begin
    mem_d = mem_q;
    if (port.we) begin
      mem_d[port.widx] = port.wdata;
    end
  end

  // register the storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        mem_q[i] <= RST_WORD;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  assign port.rdata = mem_q[port.ridx];
endmodule

// >>> hw/motion_cmd_accu_irq_ops.sv
`timescale 1ns/1ps
// Contract
// R01 - Code 34 copies the accumulator into the axis parameter picked by the type byte for the named motor; the code accepts motor 0 only.
// R02 - Code 35 copies the accumulator into the global parameter picked by the type byte in bank 0, 2 or 3.
// R03 - Global bank 2 holds the user variables, so bank 2 index 42 is user variable 42.
// R04 - A frame is address, instruction, type, motor/bank, four value bytes high first, then checksum.
// R05 - Code 36 clears the error flags chosen by the type byte and ignores the other fields.
// R06 - Clear codes are 0 all, 1 timeout, 2 alarm, 3 deviation, 4 position and 5 shutdown.
// R07 - Code 25 enables the interrupt source named in the type byte.
// R08 - Code 25 with source 255 sets the global interrupt enable.
// R09 - Code 26 disables the interrupt source named in the type byte.
// R10 - Code 26 with source 255 clears the global interrupt enable.
// R11 - The vector command stores a handler label as the entry address of the named source.
// R12 - A defined vector may be overwritten by a later vector command.
// R13 - The controller issues the vector command only from a stored program, never directly.
// R14 - The vector command is code 37 with source in the type byte and label in the value.
// R15 - Code 38 restores saved accumulator, X register, flags and program counter.
// R16 - The checksum is the byte sum of the eight leading bytes and bad frames are rejected.
// R17 - Every command answers with status 100 on success and a don't care value.
module motion_cmd_accu_irq_ops (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [motion_cmd_pkg::DATA_W-1:0] wb_dat_i, // write data
  output logic [motion_cmd_pkg::DATA_W-1:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic [motion_cmd_pkg::NUM_SRC-1:0] irq_src_i, // interrupt source pins
  input wire logic [motion_cmd_pkg::NUM_ERR-1:0] err_evt_i, // error event pins
  output logic in_handler_o, // handler running
  output logic irq_o // level interrupt to software
);
  import motion_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic ack_q, ack_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic go_q, go_d;
  logic standalone_q, standalone_d;
  logic [DATA_W-1:0] hdr_q, hdr_d, val_q, val_d;
  logic [7:0] csum_q, csum_d;
  logic [DATA_W-1:0] accu_q, accu_d, xreg_q, xreg_d;
  logic [7:0] flags_q, flags_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [DATA_W-1:0] sv_accu_q, sv_accu_d, sv_xreg_q, sv_xreg_d;
  logic [7:0] sv_flags_q, sv_flags_d;
  logic [PC_W-1:0] sv_pc_q, sv_pc_d;
  logic in_handler_q, in_handler_d;
  logic [15:0] reply_q, reply_d;
  logic [NUM_ERR-1:0] err_q, err_d;
  logic [NUM_SRC-1:0] src_en_q, src_en_d;
  logic gie_q, gie_d;
  logic [PC_W-1:0] irq_vector_define_cmd_q [NUM_SRC];
  logic [PC_W-1:0] irq_vector_define_cmd_d [NUM_SRC];
  logic [INT_W-1:0] int_stat_q, int_stat_d, int_mask_q, int_mask_d;
  logic irq_q, irq_d;
  logic [1:0] psel_bank_q, psel_bank_d;
  logic [IDX_W-1:0] psel_idx_q, psel_idx_d;
  logic [NUM_SRC-1:0] src_s1_q, src_s2_q, src_s3_q;
  logic [NUM_ERR-1:0] err_s1_q, err_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // parameter banks: axis, global 0, user variables, global 3
  param_if pb [NUM_BANKS] ();
  logic [NUM_BANKS-1:0] bank_we;
  logic [DATA_W-1:0] bank_rd [NUM_BANKS];

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    param_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .port(pb[b])
    );
    assign pb[b].we = bank_we[b];
    assign pb[b].widx = hdr_q[8+IDX_W-1:8];
    assign pb[b].wdata = accu_q;
    assign pb[b].ridx = psel_idx_q;
    assign bank_rd[b] = pb[b].rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame fields and checks
  logic [7:0] f_addr, f_op, f_type, f_bank, f_sum;
  logic [NUM_SRC-1:0] src_edge;
  logic [2:0] src_num;
  logic src_fire;
  logic acc_wr, acc_rd;

  // R04 frame field order
  assign f_addr = hdr_q[31:24];
  assign f_op = hdr_q[23:16];
  assign f_type = hdr_q[15:8];
  assign f_bank = hdr_q[7:0];
  // R16 byte sum of leading bytes
  assign f_sum = 8'(f_addr + f_op + f_type + f_bank + val_q[31:24] + val_q[23:16] + val_q[15:8] + val_q[7:0]);

  assign acc_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign acc_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign src_edge = src_s2_q & ~src_s3_q & src_en_q;

  // lowest enabled source with a rising edge
  always_comb begin
    src_num = 3'h0;
    src_fire = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (src_edge[i]) begin
        src_num = 3'(i);
        src_fire = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_s1_q <= '0;
      src_s2_q <= '0;
      src_s3_q <= '0;
      err_s1_q <= '0;
      err_s2_q <= '0;
    end else begin
      src_s1_q <= irq_src_i;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
      err_s1_q <= err_evt_i;
      err_s2_q <= err_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, command execution and interrupt entry
  always_comb begin
    logic [7:0] st;
    logic valid;
    logic entry;
    st = ST_OK;
    valid = 1'b0;
    entry = 1'b0;
    ack_d = acc_wr | acc_rd;
    rdat_d = rdat_q;
    go_d = 1'b0;
    standalone_d = standalone_q;
    hdr_d = hdr_q;
    val_d = val_q;
    csum_d = csum_q;
    accu_d = accu_q;
    xreg_d = xreg_q;
    flags_d = flags_q;
    pc_d = pc_q;
    sv_accu_d = sv_accu_q;
    sv_xreg_d = sv_xreg_q;
    sv_flags_d = sv_flags_q;
    sv_pc_d = sv_pc_q;
    in_handler_d = in_handler_q;
    reply_d = reply_q;
    err_d = err_q;
    src_en_d = src_en_q;
    gie_d = gie_q;
    irq_vector_define_cmd_d = irq_vector_define_cmd_q;
    int_stat_d = int_stat_q;
    int_mask_d = int_mask_q;
    psel_bank_d = psel_bank_q;
    psel_idx_d = psel_idx_q;
    bank_we = '0;

    // register reads, unmapped reads give zero
    if (acc_rd) begin
      case (wb_adr_i)
        REG_CTRL: rdat_d = {30'h0000_0000, standalone_q, 1'b0};
        REG_FRAME_HDR: rdat_d = hdr_q;
        REG_FRAME_VAL: rdat_d = val_q;
        REG_FRAME_CSUM: rdat_d = {24'h00_0000, csum_q};
        REG_ACCU: rdat_d = accu_q;
        REG_XREG: rdat_d = xreg_q;
        REG_PC: rdat_d = {16'h0000, pc_q};
        REG_REPLY: rdat_d = {16'h0000, reply_q};
        REG_ERR_FLAGS: rdat_d = {27'h000_0000, err_q};
        REG_IRQ_EN: rdat_d = {23'h00_0000, gie_q, src_en_q};
        REG_INT_STAT: rdat_d = {29'h0000_0000, int_stat_q};
        REG_INT_MASK: rdat_d = {29'h0000_0000, int_mask_q};
        REG_PSEL: rdat_d = {22'h00_0000, psel_bank_q, 2'h0, psel_idx_q};
        REG_PDATA: rdat_d = bank_rd[psel_bank_q];
        REG_CPU_FLAGS: rdat_d = {24'h00_0000, flags_q};
        default: rdat_d = RST_WORD;
      endcase
    end

    // register writes, full words only
    if (acc_wr && wb_sel_i == 4'hF) begin
      case (wb_adr_i)
        REG_CTRL: begin
          go_d = wb_dat_i[CTRL_GO];
          standalone_d = wb_dat_i[CTRL_STANDALONE];
        end
        REG_FRAME_HDR: hdr_d = wb_dat_i;
        REG_FRAME_VAL: val_d = wb_dat_i;
        REG_FRAME_CSUM: csum_d = wb_dat_i[7:0];
        REG_ACCU: accu_d = wb_dat_i;
        REG_XREG: xreg_d = wb_dat_i;
        REG_PC: pc_d = wb_dat_i[PC_W-1:0];
        REG_INT_STAT: int_stat_d = int_stat_q & ~wb_dat_i[INT_W-1:0];
        REG_INT_MASK: int_mask_d = wb_dat_i[INT_W-1:0];
        REG_PSEL: begin
          psel_bank_d = wb_dat_i[9:8];
          psel_idx_d = wb_dat_i[IDX_W-1:0];
        end
        REG_CPU_FLAGS: flags_d = wb_dat_i[7:0];
        default: ;
      endcase
    end

    // frames for another address are ignored silently
    if (go_q && f_addr == DEV_ADDR) begin
      valid = 1'b1;
      // R16 reject on checksum mismatch
      if (f_sum != csum_q) begin
        st = ST_BAD_CSUM;
      end else begin
        case (f_op)
          // R01 accumulator to axis parameter
          OP_ACCU_TO_AXIS: begin
            if (f_bank != 8'h00) begin
              st = ST_BAD_VALUE;
            end else if (f_type >= 8'(PARAM_DEPTH)) begin
              st = ST_BAD_TYPE;
            end else begin
              bank_we[SEL_AXIS] = 1'b1;
            end
          end
          // R02 accumulator to global parameter
          OP_ACCU_TO_GLOBAL: begin
            if (f_type >= 8'(PARAM_DEPTH)) begin
              st = ST_BAD_TYPE;
            end else if (f_bank == GBANK_0) begin
              bank_we[SEL_G0] = 1'b1;
            // R03 bank 2 is user variables
            end else if (f_bank == GBANK_USER) begin
              bank_we[SEL_G2] = 1'b1;
            end else if (f_bank == GBANK_3) begin
              bank_we[SEL_G3] = 1'b1;
            end else begin
              st = ST_BAD_VALUE;
            end
          end
          // R05 clear chosen error flags
          OP_CLEAR_ERRORS: begin
            // R06 type code selects flag
            if (f_type == CLE_ALL) begin
              err_d = '0;
            end else if (f_type <= CLE_LAST) begin
              err_d[f_type[2:0] - 3'h1] = 1'b0;
            end else begin
              st = ST_BAD_TYPE;
            end
          end
          // R07 enable one source
          OP_IRQ_ENABLE: begin
            // R08 global enable set
            if (f_type == SRC_GLOBAL) begin
              gie_d = 1'b1;
            end else if (f_type < 8'(NUM_SRC)) begin
              src_en_d[f_type[2:0]] = 1'b1;
            end else begin
              st = ST_BAD_TYPE;
            end
          end
          // R09 disable one source
          OP_IRQ_DISABLE: begin
            // R10 global enable cleared
            if (f_type == SRC_GLOBAL) begin
              gie_d = 1'b0;
            end else if (f_type < 8'(NUM_SRC)) begin
              src_en_d[f_type[2:0]] = 1'b0;
            end else begin
              st = ST_BAD_TYPE;
            end
          end
          // R14 vector command layout
          OP_VECTOR_DEFINE: begin
            // R13 stored program only
            if (!standalone_q) begin
              st = ST_BAD_CMD;
            end else if (f_type < 8'(NUM_SRC)) begin
              // R11 R12 store or overwrite label
              irq_vector_define_cmd_d[f_type[2:0]] = val_q[PC_W-1:0];
            end else begin
              st = ST_BAD_TYPE;
            end
          end
          // R15 restore saved context
          OP_IRQ_RETURN: begin
            accu_d = sv_accu_q;
            xreg_d = sv_xreg_q;
            flags_d = sv_flags_q;
            pc_d = sv_pc_q;
            in_handler_d = 1'b0;
          end
          default: st = ST_BAD_CMD;
        endcase
      end
      // R17 reply status and echoed code
      reply_d = {st, f_op};
    end

    // handler entry saves context, commands take priority
    if (!valid && src_fire && gie_q && standalone_q && !in_handler_q) begin
      entry = 1'b1;
      sv_accu_d = accu_q;
      sv_xreg_d = xreg_q;
      sv_flags_d = flags_q;
      sv_pc_d = pc_q;
      pc_d = irq_vector_define_cmd_q[src_num];
      in_handler_d = 1'b1;
    end

    // hardware events win over a clear in the same cycle
    err_d = err_d | err_s2_q;
    int_stat_d[INT_DONE] = int_stat_d[INT_DONE] | (valid && st == ST_OK);
    int_stat_d[INT_REJECT] = int_stat_d[INT_REJECT] | (valid && st != ST_OK);
    int_stat_d[INT_ENTRY] = int_stat_d[INT_ENTRY] | entry;
    irq_d = |(int_stat_q & int_mask_q);
  end

  // register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= RST_WORD;
      go_q <= 1'b0;
      standalone_q <= 1'b0;
      hdr_q <= RST_WORD;
      val_q <= RST_WORD;
      csum_q <= 8'h00;
      accu_q <= RST_WORD;
      xreg_q <= RST_WORD;
      flags_q <= 8'h00;
      pc_q <= 16'h0000;
      sv_accu_q <= RST_WORD;
      sv_xreg_q <= RST_WORD;
      sv_flags_q <= 8'h00;
      sv_pc_q <= 16'h0000;
      in_handler_q <= 1'b0;
      reply_q <= 16'h0000;
      err_q <= '0;
      src_en_q <= '0;
      gie_q <= 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
        irq_vector_define_cmd_q[i] <= 16'h0000;
      end
      int_stat_q <= '0;
      int_mask_q <= '0;
      irq_q <= 1'b0;
      psel_bank_q <= 2'h0;
      psel_idx_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      go_q <= go_d;
      standalone_q <= standalone_d;
      hdr_q <= hdr_d;
      val_q <= val_d;
      csum_q <= csum_d;
      accu_q <= accu_d;
      xreg_q <= xreg_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      sv_accu_q <= sv_accu_d;
      sv_xreg_q <= sv_xreg_d;
      sv_flags_q <= sv_flags_d;
      sv_pc_q <= sv_pc_d;
      in_handler_q <= in_handler_d;
      reply_q <= reply_d;
      err_q <= err_d;
      src_en_q <= src_en_d;
      gie_q <= gie_d;
      irq_vector_define_cmd_q <= irq_vector_define_cmd_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      irq_q <= irq_d;
      psel_bank_q <= psel_bank_d;
      psel_idx_q <= psel_idx_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o = irq_q;
  assign in_handler_o = in_handler_q;
endmodule

// >>> verification/accu_irq_props.sv
`timescale 1ns/1ps
module accu_irq_props
  import motion_cmd_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [motion_cmd_pkg::DATA_W-1:0] wb_dat_i, // write data
  input wire logic [motion_cmd_pkg::DATA_W-1:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic [motion_cmd_pkg::NUM_SRC-1:0] irq_src_i, // sources
  input wire logic [motion_cmd_pkg::NUM_ERR-1:0] err_evt_i, // error pins
  input wire logic in_handler_o, // handler running
  input wire logic irq_o // interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ack;
  // a read being answered this cycle
  assign rd_ack = wb_ack_o && !wb_we_i;
  ////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_rdata_hold: assert property ($changed(wb_dat_o) |-> rd_ack) else $error("read data moved");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i > REG_CPU_FLAGS |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  a_go_reads_zero: assert property (rd_ack && wb_adr_i == REG_CTRL |-> !wb_dat_o[CTRL_GO])
    else $error("go bit reads one");
  a_err_width: assert property (rd_ack && wb_adr_i == REG_ERR_FLAGS |-> wb_dat_o[31:NUM_ERR] == '0)
    else $error("stray error bits");
  a_en_width: assert property (rd_ack && wb_adr_i == REG_IRQ_EN |-> wb_dat_o[31:9] == '0)
    else $error("stray enable bits");
  a_mask_off: assert property (wb_ack_o && wb_we_i && wb_sel_i == 4'hF && wb_adr_i == REG_INT_MASK
    && wb_dat_i == '0 |-> ##2 !irq_o [*2]) else $error("irq with mask clear");
  a_handler_exit: assert property ($fell(in_handler_o) |->
    $past(wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_dat_i[CTRL_GO], 1)) else $error("exit without go");
  // main scenarios reached
  cover property ($rose(in_handler_o));
  cover property ($rose(irq_o));
  cover property ($fell(in_handler_o));
endmodule

bind motion_cmd_accu_irq_ops accu_irq_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_src_i, .err_evt_i, .in_handler_o, .irq_o);

// >>> verification/frame_host.sv
`timescale 1ns/1ps
module frame_host
  import motion_cmd_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic ack_i, // acknowledge
  output logic cyc_o, // cycle
  output logic stb_o, // strobe
  output logic we_o, // write
  output logic [7:0] adr_o, // address
  output logic [3:0] sel_o, // lanes
  output logic [DATA_W-1:0] dat_o // write data
);
  logic sa = 1'b0;
  // bus idle at time zero
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  ////////////////////////////////////////////////////////////
  // one classic cycle, request held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    {cyc_o, stb_o, we_o} <= 3'b000;
    adr_o <= ~a; // released lines drop the old value
    dat_o <= ~d;
  endtask
  // go carries the standalone bit the program sets
  task automatic frame(input logic [7:0] op, ty, mb, input logic [31:0] v, input logic [7:0] bad);
    logic [7:0] cs;
    cs = DEV_ADDR + op + ty + mb + v[31:24] + v[23:16] + v[15:8] + v[7:0] + bad;
    xfer(1'b1, REG_FRAME_HDR, 4'hF, {DEV_ADDR, op, ty, mb});
    xfer(1'b1, REG_FRAME_VAL, 4'hF, v);
    xfer(1'b1, REG_FRAME_CSUM, 4'hF, {24'h00_0000, cs});
    xfer(1'b1, REG_CTRL, 4'hF, {30'h0000_0000, sa, 1'b1});
  endtask
endmodule

// >>> verification/motion_cmd_accu_irq_ops_tb.sv
`timescale 1ns/1ps
module motion_cmd_accu_irq_ops_tb;
  import motion_cmd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc, stb, we, ack, in_h, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [DATA_W-1:0] dw, dr, acc;
  logic [NUM_SRC-1:0] src = '0;
  logic [NUM_ERR-1:0] err = '0;
  logic [15:0] lf = 16'h000A;
  logic [DATA_W-1:0] exp_q[$];
  logic [7:0] banks[3] = '{GBANK_0, GBANK_USER, GBANK_3};
  logic [1:0] sels[3] = '{SEL_G0, SEL_G2, SEL_G3};
  int err_count = 0;
  int checks = 0;
  int n;
  // clock
  always #2 clk = ~clk;
  motion_cmd_accu_irq_ops dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .irq_src_i(src),
    .err_evt_i(err), .in_handler_o(in_h), .irq_o(irq));
  frame_host host (.clk_i(clk), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(dw));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return {lf, ~lf};
  endfunction
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("MISMATCH %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic want);
    cmp({31'h0000_0000, got}, {31'h0000_0000, want});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 4'hF, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, 4'hF, d);
  endtask
  task automatic cmd(input logic [7:0] op, ty, mb, input logic [31:0] v, input logic [7:0] st, bad);
    host.frame(op, ty, mb, v, bad);
    rd(REG_REPLY, {16'h0000, st, op});
  endtask
  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // read answers matched against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0)
      cmp(dr, exp_q.pop_front());
  end
  // watchdog
  initial begin
    #80000;
    err_count++;
    close_out();
  end
  // stimulus
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    acc = rnd();
    wr(REG_ACCU, acc);
    cmd(OP_ACCU_TO_AXIS, 8'd63, 8'h00, ~acc, ST_OK, 8'h00);
    wr(REG_PSEL, {22'h00_0000, SEL_AXIS, 8'h3F});
    rd(REG_PDATA, acc);
    for (int i = 0; i < 3; i++) begin
      acc = rnd();
      wr(REG_ACCU, acc);
      cmd(OP_ACCU_TO_GLOBAL, 8'd42, banks[i], 32'h0000_0000, ST_OK, 8'h00);
      wr(REG_PSEL, {22'h00_0000, sels[i], 8'd42});
      rd(REG_PDATA, acc);
    end
    cmd(OP_ACCU_TO_GLOBAL, 8'd42, 8'h01, 32'h0000_0000, ST_BAD_VALUE, 8'h00);
    cmd(OP_ACCU_TO_AXIS, 8'h00, 8'h00, 32'h0000_0000, ST_BAD_CSUM, 8'h01);
    cmd(OP_ACCU_TO_AXIS, 8'd0, 8'h01, 32'h0000_0000, ST_BAD_VALUE, 8'h00);
    cmd(OP_ACCU_TO_AXIS, 8'd64, 8'h00, 32'h0000_0000, ST_BAD_TYPE, 8'h00);
    cmd(8'd99, 8'h00, 8'h00, 32'h0000_0000, ST_BAD_CMD, 8'h00);
    for (int c = 5; c >= 0; c--) begin
      err <= '1;
      @(posedge clk);
      err <= '0;
      repeat (4) @(posedge clk);
      cmd(OP_CLEAR_ERRORS, c[7:0], 8'h5A, rnd(), ST_OK, 8'h00);
      rd(REG_ERR_FLAGS, (c == 0) ? 32'h0000_0000 : 32'h0000_001F & ~(32'h0000_0001 << (c - 1)));
    end
    cmd(OP_CLEAR_ERRORS, 8'd6, 8'h00, 32'h0000_0000, ST_BAD_TYPE, 8'h00);
    cmd(OP_IRQ_ENABLE, 8'd7, 8'h33, rnd(), ST_OK, 8'h00);
    rd(REG_IRQ_EN, 32'h0000_0080);
    cmd(OP_IRQ_ENABLE, SRC_GLOBAL, 8'h00, 32'h0000_0000, ST_OK, 8'h00);
    rd(REG_IRQ_EN, 32'h0000_0180);
    cmd(OP_IRQ_DISABLE, 8'd7, 8'h11, rnd(), ST_OK, 8'h00);
    rd(REG_IRQ_EN, 32'h0000_0100);
    cmd(OP_IRQ_DISABLE, SRC_GLOBAL, 8'h00, 32'h0000_0000, ST_OK, 8'h00);
    rd(REG_IRQ_EN, 32'h0000_0000);
    cmd(OP_IRQ_ENABLE, 8'd8, 8'h00, 32'h0000_0000, ST_BAD_TYPE, 8'h00);
    cmd(OP_VECTOR_DEFINE, 8'd0, 8'h00, 32'h0000_0050, ST_BAD_CMD, 8'h00);
    host.sa = 1'b1;
    cmd(OP_VECTOR_DEFINE, 8'd0, 8'h00, 32'h0000_0050, ST_OK, 8'h00);
    cmd(OP_VECTOR_DEFINE, 8'd0, 8'h00, 32'h0000_0064, ST_OK, 8'h00);
    cmd(OP_IRQ_ENABLE, 8'd0, 8'h00, 32'h0000_0000, ST_OK, 8'h00);
    cmd(OP_IRQ_ENABLE, SRC_GLOBAL, 8'h00, 32'h0000_0000, ST_OK, 8'h00);
    acc = rnd();
    wr(REG_ACCU, acc);
    wr(REG_PC, 32'h0000_0123);
    wr(REG_INT_STAT, 32'h0000_0007);
    wr(REG_XREG, ~acc);
    wr(REG_CPU_FLAGS, 32'h0000_005A);
    src <= 8'h01;
    n = 0;
    while (in_h !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    src <= 8'h00;
    cmp_flag(in_h, 1'b1);
    rd(REG_PC, 32'h0000_0064);
    rd(REG_INT_STAT, 32'h0000_0004);
    wr(REG_INT_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk);
    cmp_flag(irq, 1'b1);
    wr(REG_INT_STAT, 32'h0000_0004);
    repeat (3) @(posedge clk);
    cmp_flag(irq, 1'b0);
    wr(REG_ACCU, ~acc);
    wr(REG_XREG, acc);
    wr(REG_CPU_FLAGS, 32'h0000_00A5);
    cmd(OP_IRQ_RETURN, 8'd0, 8'h00, 32'h0000_0000, ST_OK, 8'h00);
    rd(REG_ACCU, acc);
    rd(REG_PC, 32'h0000_0123);
    rd(REG_XREG, ~acc);
    rd(REG_CPU_FLAGS, 32'h0000_005A);
    cmp_flag(in_h, 1'b0);
    host.xfer(1'b1, REG_ACCU, 4'h3, 32'h0000_0000);
    rd(REG_ACCU, acc);
    rd(8'h3C, 32'h0000_0000);
    wr(REG_INT_MASK, 32'h0000_0007);
    repeat (3) @(posedge clk);
    cmp_flag(irq, 1'b1);
    wr(REG_INT_MASK, 32'h0000_0000);
    repeat (4) @(posedge clk);
    cmp_flag(irq, 1'b0);
    close_out();
  end
endmodule
